// ===== verilog/mpu_region_attribute_access.sv
// Notes on behaviour
// - Attribute register exists only when the protection unit is configured in.
// - Build parameter picks size-mask or upper-limit field, never both.
// - Attribute register holds part of region; base lives in base register.
// - Size-mask field is exactly as wide as the base field.
// - Unused mask bits read zero; software writes them zero.
// - Mask is all-ones shifted left by log2(size/64); zero means 2 GB.
// - In mask variant bit 31 is not part of the mask.
// - Limit holds highest address plus one, scaled like the base.
// - Limit is one bit wider than base and uses bit 31.
// - Cacheable flag sets default data cacheability: one cached, zero uncached.
// - Instruction regions write cacheable as zero; it always reads zero.
// - Cached only with a data cache; uncached load/store force uncached.
// - Address bit 31 cache bypass stays supported with protection present.
// - Instruction permission: 0 none, 1 supervisor execute, 2 both execute.
// - Data permission: 0,1,2,4,5,6 decode to documented read/write rights.
// - Attribute write with read trigger loads selected region into registers.
// - Attribute write with write trigger stores base and attributes to region.
// - Trigger flags are write-only and always read back zero.
// - All attribute fields reset to zero.
// - Region read: select region in base register, then triggered attribute write.
// - Base and attribute writes do not request a pipeline flush.
// - Base field is 25 bits, address bits 30 to 6, 64-byte granules.
// - Protection is disabled after reset until enable bit is set.
`timescale 1ns/100ps
`default_nettype none
module mpu_region_attribute_access
    import region_attr_pkg::*;
#(
    parameter bit                MPU_PRESENT   = 1'b1,
    parameter bit                USE_LIMIT     = 1'b0,
    parameter bit                DCACHE_PRESENT = 1'b1,
    parameter logic [IDX_W-1:0]  LOOKUP_REGION = 5'h00
)
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ctlWrEn,
    input  wire logic [1:0]  ctlSel,
    input  wire logic [31:0] ctlWrData,
    output logic      [31:0] ctlRdData,
    output logic             flushReq,
    output logic             busy,
    output logic             protectionEnable,
    input  wire logic        dataAccess,
    input  wire logic        supervisorMode,
    input  wire logic        isWrite,
    input  wire logic        uncachedOp,
    input  wire logic [31:0] accessAddr,
    output logic             regionHit,
    output logic             accessAllowed,
    output logic             accessCacheable
);
    localparam int HI_W = USE_LIMIT ? LIMIT_W : BASE_W;

    // ****************************************
    // Register state
    // ****************************************
    logic [BASE_W-1:0]  baseField_r;
    logic [IDX_W-1:0]   regionIdx_r;
    logic               dataSel_r;
    logic [LIMIT_W-1:0] hiField_r;
    logic               cacheFlag_r;
    logic [ACCESS_PERMISSION_CODE_W-1:0]  accessPermissionCode_r;
    logic               protectionEnableBit_r;
    xfer_type           state_r;
    xfer_type           state_nxt;

    logic [ENTRY_W-1:0] memRdData;
    logic [IDX_W:0]     memRdAddr;

    // ****************************************
    // Write decode
    // ****************************************
    wire wrBase   = MPU_PRESENT && ctlWrEn && (ctlSel == SEL_BASE);
    wire wrAcc    = MPU_PRESENT && ctlWrEn && (ctlSel == SEL_ACC);
    wire wrCfg    = MPU_PRESENT && ctlWrEn && (ctlSel == SEL_CONFIG);
    wire trigRd   = wrAcc && ctlWrData[ACC_RD_BIT] && !ctlWrData[ACC_WR_BIT];
    wire trigWr   = wrAcc && ctlWrData[ACC_WR_BIT] && !ctlWrData[ACC_RD_BIT];
    wire idle     = (state_r == ST_IDLE);

    // Hi field: mask keeps bits 30..6 only, limit also takes bit 31
    wire [LIMIT_W-1:0] hiIn = USE_LIMIT ? ctlWrData[31:ACC_HI_LSB]
                                        : {1'b0, ctlWrData[30:ACC_HI_LSB]};
    // Instruction regions never hold a cacheable flag
    wire cacheIn = dataSel_r && ctlWrData[ACC_C_BIT];

    // A region write stores the attribute fields carried by that same write plus the base register, not the old attribute register contents
    wire [ENTRY_W-1:0] entryOut = {hiIn, cacheIn, ctlWrData[ACC_ACCESS_PERMISSION_CODE_LSB +: ACCESS_PERMISSION_CODE_W], baseField_r};

    // Only the fetch cycle addresses the selected region, so the lookup has its own entry back once idle
    assign memRdAddr = (state_r == ST_FETCH) ? {dataSel_r, regionIdx_r} : {1'b1, LOOKUP_REGION};

    region_table_mem u_table
    (
        .mclk   (mclk),
        .wrEn   (trigWr && idle),
        .wrAddr ({dataSel_r, regionIdx_r}),
        .wrData (entryOut),
        .rdAddr (memRdAddr),
        .rdData (memRdData)
    );

    // ****************************************
    // Region load sequence
    // ****************************************
    // One cycle to address the table, one to capture its registered output
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  if (trigRd) state_nxt = ST_FETCH;
            ST_FETCH: state_nxt = ST_LOAD;
            ST_LOAD:  state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    wire loadNow = (state_r == ST_LOAD);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            baseField_r  <= BASE_RESET[BASE_W-1:0];
            regionIdx_r  <= BASE_RESET[IDX_W-1:0];
            dataSel_r    <= 1'b0;
        end
        else if (loadNow)
        begin
            baseField_r  <= memRdData[BASE_W-1:0];
        end
        else if (wrBase && idle)
        begin
            baseField_r  <= ctlWrData[30:BR_BASE_LSB];
            regionIdx_r  <= ctlWrData[BR_IDX_LSB +: IDX_W];
            dataSel_r    <= ctlWrData[BR_D_BIT];
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            hiField_r              <= ACC_RESET[LIMIT_W-1:0];
            cacheFlag_r            <= 1'b0;
            accessPermissionCode_r <= ACC_RESET[ACCESS_PERMISSION_CODE_W-1:0];
        end
        else if (loadNow)
        begin
            {hiField_r, cacheFlag_r, accessPermissionCode_r} <= memRdData[ENTRY_W-1:BASE_W];
        end
        else if (wrAcc && !trigRd && idle)
        begin
            hiField_r              <= hiIn;
            cacheFlag_r            <= cacheIn;
            accessPermissionCode_r <= ctlWrData[ACC_ACCESS_PERMISSION_CODE_LSB +: ACCESS_PERMISSION_CODE_W];
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            protectionEnableBit_r <= 1'b0;
        end
        else if (wrCfg)
        begin
            protectionEnableBit_r <= ctlWrData[0];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire [31:0] accRead = {USE_LIMIT ? hiField_r[LIMIT_W-1] : 1'b0,
                           hiField_r[BASE_W-1:0], dataSel_r & cacheFlag_r,
                           accessPermissionCode_r, 2'b00};
    wire [31:0] baseRead = {1'b0, baseField_r, regionIdx_r, dataSel_r};

    always_comb
    begin
        ctlRdData = 32'h0000_0000;
        if (MPU_PRESENT)
        begin
            if (ctlSel == SEL_BASE)
                ctlRdData = baseRead;
            else if (ctlSel == SEL_ACC)
                ctlRdData = accRead;
            else if (ctlSel == SEL_CONFIG)
                ctlRdData = {31'h0, protectionEnableBit_r};
        end
    end

    assign flushReq         = 1'b0;
    assign busy             = !idle;
    assign protectionEnable = protectionEnableBit_r;

    // ****************************************
    // Lookup of the monitored region
    // ****************************************
    // Only one region is checked per cycle; a full core would replicate this per index
    wire [LIMIT_W-1:0] lkHi   = memRdData[ENTRY_W-1 -: LIMIT_W];
    wire               lkC    = memRdData[BASE_W + ACCESS_PERMISSION_CODE_W];
    wire [ACCESS_PERMISSION_CODE_W-1:0]  lkPerm = memRdData[BASE_W +: ACCESS_PERMISSION_CODE_W];
    wire [BASE_W-1:0]  lkBase = memRdData[BASE_W-1:0];
    wire [BASE_W-1:0]  addrG  = accessAddr[30:BASE_LSB];

    wire maskHit  = ((addrG & lkHi[BASE_W-1:0]) == lkBase);
    wire limitHit = (lkBase <= addrG) && ({1'b0, addrG} < lkHi);

    function automatic logic permOk(input logic [2:0] code, input logic dat,
                                    input logic sup, input logic wr);
        logic ok;
        ok = 1'b0;
        if (!dat)
            ok = (code == 3'h2) || ((code == 3'h1) && sup);
        else
            case (code)
                ACCESS_PERMISSION_CODE_SV_R:    ok = sup && !wr;
                ACCESS_PERMISSION_CODE_ALL_R:   ok = !wr;
                ACCESS_PERMISSION_CODE_SV_RW:   ok = sup;
                ACCESS_PERMISSION_CODE_SVRW_UR: ok = sup || !wr;
                ACCESS_PERMISSION_CODE_ALL_RW:  ok = 1'b1;
                default:      ok = 1'b0;
            endcase
        return ok;
    endfunction

    assign regionHit       = protectionEnableBit_r && idle && (USE_LIMIT ? limitHit : maskHit);
    assign accessAllowed   = !protectionEnableBit_r || (regionHit && permOk(lkPerm, dataAccess,
                             supervisorMode, isWrite));
    assign accessCacheable = DCACHE_PRESENT && dataAccess && !uncachedOp
                             && !accessAddr[31] && (!protectionEnableBit_r || (regionHit && lkC));
endmodule
`default_nettype wire

// ===== verilog/region_attr_pkg.sv
`default_nettype none
package region_attr_pkg;
    // Region base field covers address bits 30..6
    localparam int BASE_W       = 25;
    localparam int BASE_LSB     = 6;
    localparam int LIMIT_W      = 26;
    localparam int IDX_W        = 5;
    localparam int NUM_REGIONS  = 32;
    // Attribute register field positions
    localparam int ACC_WR_BIT   = 0;
    localparam int ACC_RD_BIT   = 1;
    localparam int ACC_ACCESS_PERMISSION_CODE_LSB = 2;
    localparam int ACCESS_PERMISSION_CODE_W       = 3;
    localparam int ACC_C_BIT    = 5;
    localparam int ACC_HI_LSB   = 6;
    // Base register field positions
    localparam int BR_D_BIT     = 0;
    localparam int BR_IDX_LSB   = 1;
    localparam int BR_BASE_LSB  = 6;
    // Reset values
    localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    // Table entry: hi field (LIMIT_W), C, access_permission_code, base
    localparam int ENTRY_W = LIMIT_W + 1 + ACCESS_PERMISSION_CODE_W + BASE_W;
    // Control-register selectors
    localparam logic [1:0] SEL_BASE   = 2'h0;
    localparam logic [1:0] SEL_ACC    = 2'h1;
    localparam logic [1:0] SEL_CONFIG = 2'h2;
    // Permission codes
    localparam logic [2:0] ACCESS_PERMISSION_CODE_NONE   = 3'h0;
    localparam logic [2:0] ACCESS_PERMISSION_CODE_SV_R   = 3'h1;
    localparam logic [2:0] ACCESS_PERMISSION_CODE_ALL_R  = 3'h2;
    localparam logic [2:0] ACCESS_PERMISSION_CODE_SV_RW  = 3'h4;
    localparam logic [2:0] ACCESS_PERMISSION_CODE_SVRW_UR = 3'h5;
    localparam logic [2:0] ACCESS_PERMISSION_CODE_ALL_RW = 3'h6;
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_LOAD  = 3'b100
    } xfer_type;
endpackage
`default_nettype wire

// ===== verilog/region_table_mem.sv
`timescale 1ns/100ps
`default_nettype none
module region_table_mem
    import region_attr_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   wrEn,
    input  wire logic [IDX_W:0]         wrAddr,
    input  wire logic [ENTRY_W-1:0]     wrData,
    input  wire logic [IDX_W:0]         rdAddr,
    output logic      [ENTRY_W-1:0]     rdData
);
    // No reset: region contents are undefined until software programs them
    logic [ENTRY_W-1:0] store [0:2*NUM_REGIONS-1];

    always_ff @(posedge mclk)
    begin
        if (wrEn)
        begin
            store[wrAddr] <= wrData;
        end
        rdData <= store[rdAddr];
    end
endmodule
`default_nettype wire

// ===== dv/mpu_region_attribute_access_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Control register and lookup output checks
// ****************************************
module mpu_region_attribute_access_asserts
    import region_attr_pkg::*;
#(
    parameter bit USE_LIMIT = 1'b0
)
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        ctlWrEn,
    input wire logic [1:0]  ctlSel,
    input wire logic [31:0] ctlWrData,
    input wire logic [31:0] ctlRdData,
    input wire logic        flushReq,
    input wire logic        busy,
    input wire logic        protectionEnable,
    input wire logic        uncachedOp,
    input wire logic [31:0] accessAddr,
    input wire logic        accessAllowed,
    input wire logic        accessCacheable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Base and attribute writes during a region load are dropped, so only idle writes count
    wire       accWr    = ctlWrEn && ctlSel == SEL_ACC && !busy;
    wire [27:0] wrFields = {ctlWrData[30:6], ctlWrData[4:2]};
    wire [27:0] rdFields = {ctlRdData[30:6], ctlRdData[4:2]};
    a_no_flush: assert property (flushReq == 1'b0)
        else $error("flush requested");
    a_flags_read_zero: assert property (ctlSel == SEL_ACC |-> ctlRdData[1:0] == 2'h0)
        else $error("trigger flags read nonzero");
    a_read_load_busy: assert property (accWr && ctlWrData[1:0] == 2'h2 |=> busy [*2] ##1 !busy)
        else $error("region load timing wrong");
    a_mask_top_zero: assert property (!USE_LIMIT && ctlSel == SEL_ACC |-> !ctlRdData[31])
        else $error("bit 31 set in mask variant");
    a_enable_follows: assert property (ctlWrEn && ctlSel == SEL_CONFIG |=>
        protectionEnable == $past(ctlWrData[0]))
        else $error("enable bit not written");
    a_reset_clear: assert property ($rose(nrst) |-> ctlRdData == 32'h0 && !protectionEnable)
        else $error("nonzero value after reset");
    a_fields_stored: assert property (accWr && ctlWrData[1:0] == 2'h0 ##1 ctlSel == SEL_ACC |->
        rdFields == $past(wrFields))
        else $error("attribute fields not stored");
    a_uncached_op: assert property (uncachedOp |-> !accessCacheable)
        else $error("uncached access marked cacheable");
    a_bypass_bit: assert property (accessAddr[31] |-> !accessCacheable)
        else $error("bypass address marked cacheable");
    c_region_read: cover property (accWr && ctlWrData[1:0] == 2'h2);
    c_region_write: cover property (accWr && ctlWrData[1:0] == 2'h1);
    c_cached_allowed: cover property (accessCacheable && accessAllowed);
endmodule
bind mpu_region_attribute_access mpu_region_attribute_access_asserts #(.USE_LIMIT(USE_LIMIT)) u_asserts (
    .mclk(mclk), .nrst(nrst), .ctlWrEn(ctlWrEn), .ctlSel(ctlSel), .ctlWrData(ctlWrData),
    .ctlRdData(ctlRdData), .flushReq(flushReq), .busy(busy), .protectionEnable(protectionEnable),
    .uncachedOp(uncachedOp), .accessAddr(accessAddr), .accessAllowed(accessAllowed),
    .accessCacheable(accessCacheable));
`default_nettype wire

// ===== dv/core_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Core control-register write and read path
// ****************************************
module core_ctl_model
    import region_attr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        busy,
    input  wire logic [31:0] ctlRdData,
    output logic             ctlWrEn,
    output logic      [1:0]  ctlSel,
    output logic      [31:0] ctlWrData
);
    // Counts accesses that gave up waiting for a region load; the bench fails on any
    int stalls = 0;
    initial
    begin
        ctlWrEn = 1'b0;
        ctlSel = SEL_BASE;
        ctlWrData = 32'h0;
    end
    // The core stalls its next access while a region load is running
    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        @(negedge mclk);
        repeat (8) if (busy) @(negedge mclk);
        if (busy) stalls++;
        ctlSel = sel;
        ctlWrData = d;
        ctlWrEn = 1'b1;
        @(negedge mclk);
        ctlWrEn = 1'b0;
        // Data is not held after the strobe, so stale values cannot pass
        ctlWrData = ~d;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [31:0] d);
        @(negedge mclk);
        repeat (8) if (busy) @(negedge mclk);
        if (busy) stalls++;
        ctlSel = sel;
        #1;
        d = ctlRdData;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_mpu_region_attribute_access.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Register sequences and lookups
// ****************************************
module tb_mpu_region_attribute_access
    import region_attr_pkg::*;
;
    logic        mclk = 1'b0;
    logic        nrst, ctlWrEn, flushReq, busy, protectionEnable, regionHit, accessAllowed, accessCacheable;
    logic        dataAccess, supervisorMode, isWrite, uncachedOp, limHit;
    logic [1:0]  ctlSel;
    logic [31:0] ctlWrData, ctlRdData, accessAddr, v, limRdData;
    logic [2:0]  perms [6] = '{ACCESS_PERMISSION_CODE_NONE, ACCESS_PERMISSION_CODE_SV_R, ACCESS_PERMISSION_CODE_ALL_R, ACCESS_PERMISSION_CODE_SV_RW, ACCESS_PERMISSION_CODE_SVRW_UR, ACCESS_PERMISSION_CODE_ALL_RW};
    int          fails = 0;
    int          checked = 0;
    always #2.5 mclk = ~mclk;
    mpu_region_attribute_access u_dut (.mclk(mclk), .nrst(nrst), .ctlWrEn(ctlWrEn), .ctlSel(ctlSel),
        .ctlWrData(ctlWrData), .ctlRdData(ctlRdData), .flushReq(flushReq), .busy(busy),
        .protectionEnable(protectionEnable), .dataAccess(dataAccess), .supervisorMode(supervisorMode),
        .isWrite(isWrite), .uncachedOp(uncachedOp), .accessAddr(accessAddr), .regionHit(regionHit),
        .accessAllowed(accessAllowed), .accessCacheable(accessCacheable));
    core_ctl_model u_core (.mclk(mclk), .busy(busy), .ctlRdData(ctlRdData), .ctlWrEn(ctlWrEn),
        .ctlSel(ctlSel), .ctlWrData(ctlWrData));
    // Second build with the upper-limit field, fed from the same control path
    mpu_region_attribute_access #(.USE_LIMIT(1'b1)) u_limit (.mclk(mclk), .nrst(nrst), .ctlWrEn(ctlWrEn),
        .ctlSel(ctlSel), .ctlWrData(ctlWrData), .ctlRdData(limRdData), .flushReq(), .busy(), .protectionEnable(),
        .dataAccess(dataAccess), .supervisorMode(supervisorMode), .isWrite(isWrite), .uncachedOp(uncachedOp),
        .accessAddr(accessAddr), .regionHit(limHit), .accessAllowed(), .accessCacheable());
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic [31:0] bv(input logic [24:0] b, input logic [4:0] i, input logic d);
        return {1'b0, b, i, d};
    endfunction
    function automatic logic [31:0] av(input logic [24:0] m, input logic c, input logic [2:0] p,
                                       input logic [1:0] t);
        return {1'b0, m, c, p, t};
    endfunction
    function automatic logic allow(input logic [2:0] p, input logic s, input logic w);
        if (s)
            return w ? p[2] : (p != 3'h0);
        return w ? (p == 3'h6) : (p == 3'h2 || p == 3'h5 || p == 3'h6);
    endfunction
    task automatic look(input logic s, input logic w, input logic u, input logic [31:0] a);
        @(negedge mclk);
        supervisorMode = s;
        isWrite = w;
        uncachedOp = u;
        accessAddr = a;
        #1;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        final_report();
    end
    initial
    begin
        nrst = 1'b0;
        dataAccess = 1'b1;
        supervisorMode = 1'b1;
        isWrite = 1'b0;
        uncachedOp = 1'b0;
        accessAddr = 32'h0000_4010;
        repeat (4) @(posedge mclk);
        @(negedge mclk) nrst = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            u_core.rd(s[1:0], v);
            chk("reset read", v, 32'h0);
        end
        chk("enable at reset", {31'h0, protectionEnable}, 32'h0);
        u_core.wr(SEL_CONFIG, 32'h1);
        chk("enable set", {31'h0, protectionEnable}, 32'h1);
        u_core.wr(SEL_BASE, bv(25'h100, 5'h03, 1'b1));
        u_core.wr(SEL_ACC, av(25'h1FFFFFC, 1'b1, ACCESS_PERMISSION_CODE_SVRW_UR, 2'h1));
        u_core.rd(SEL_ACC, v);
        chk("attr after store", v, av(25'h1FFFFFC, 1'b1, ACCESS_PERMISSION_CODE_SVRW_UR, 2'h0));
        u_core.wr(SEL_BASE, bv(25'h0, 5'h04, 1'b1));
        u_core.wr(SEL_ACC, 32'h0);
        u_core.wr(SEL_BASE, bv(25'h0, 5'h03, 1'b1));
        u_core.wr(SEL_ACC, 32'h2);
        chk("busy after read trigger", {31'h0, busy}, 32'h1);
        u_core.rd(SEL_BASE, v);
        chk("base loaded", v, bv(25'h100, 5'h03, 1'b1));
        u_core.rd(SEL_ACC, v);
        chk("attr loaded", v, av(25'h1FFFFFC, 1'b1, ACCESS_PERMISSION_CODE_SVRW_UR, 2'h0));
        foreach (perms[k])
        begin
            u_core.wr(SEL_BASE, bv(25'h100, 5'h00, 1'b1));
            u_core.wr(SEL_ACC, av(25'h1FFFFFC, 1'b1, perms[k], 2'h1));
            for (int m = 0; m < 4; m++)
            begin
                look(m[1], m[0], 1'b0, 32'h0000_40C0);
                chk("hit", {31'h0, regionHit}, 32'h1);
                chk("allowed", {31'h0, accessAllowed}, {31'h0, allow(perms[k], m[1], m[0])});
            end
        end
        chk("cacheable", {31'h0, accessCacheable}, 32'h1);
        look(1'b1, 1'b0, 1'b1, 32'h0000_4010);
        chk("uncached op", {31'h0, accessCacheable}, 32'h0);
        look(1'b1, 1'b0, 1'b0, 32'h8000_4010);
        chk("bypass bit", {31'h0, accessCacheable}, 32'h0);
        look(1'b1, 1'b0, 1'b0, 32'h0000_4100);
        chk("miss", {31'h0, regionHit}, 32'h0);
        u_core.wr(SEL_ACC, av(25'h1FFFFFC, 1'b0, ACCESS_PERMISSION_CODE_ALL_RW, 2'h1));
        look(1'b1, 1'b0, 1'b0, 32'h0000_4010);
        chk("uncacheable region", {31'h0, accessCacheable}, 32'h0);
        u_core.wr(SEL_ACC, av(25'h1FFFFFC, 1'b0, ACCESS_PERMISSION_CODE_ALL_R, 2'h1));
        dataAccess = 1'b0;
        look(1'b0, 1'b1, 1'b0, 32'h0000_4010);
        chk("user execute", {31'h0, accessAllowed}, 32'h1);
        u_core.wr(SEL_ACC, av(25'h1FFFFFC, 1'b0, ACCESS_PERMISSION_CODE_SV_R, 2'h1));
        look(1'b0, 1'b1, 1'b0, 32'h0000_4010);
        chk("user no execute", {31'h0, accessAllowed}, 32'h0);
        look(1'b1, 1'b1, 1'b0, 32'h0000_4010);
        chk("supervisor execute", {31'h0, accessAllowed}, 32'h1);
        u_core.wr(SEL_ACC, av(25'h104, 1'b1, ACCESS_PERMISSION_CODE_ALL_RW, 2'h1));
        look(1'b1, 1'b0, 1'b0, 32'h0000_40C0);
        chk("limit hit", {31'h0, limHit}, 32'h1);
        look(1'b1, 1'b0, 1'b0, 32'h0000_4100);
        chk("limit miss", {31'h0, limHit}, 32'h0);
        u_core.wr(SEL_ACC, 32'h8000_0000 | av(25'h104, 1'b1, ACCESS_PERMISSION_CODE_ALL_RW, 2'h0));
        u_core.rd(SEL_ACC, v);
        chk("limit top bit", limRdData, 32'h8000_0000 | av(25'h104, 1'b1, ACCESS_PERMISSION_CODE_ALL_RW, 2'h0));
        chk("mask top bit", v, av(25'h104, 1'b1, ACCESS_PERMISSION_CODE_ALL_RW, 2'h0));
        chk("no flush", {31'h0, flushReq}, 32'h0);
        chk("core stalls", u_core.stalls, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
